// >>> common/tgqd_pkg.sv
/*
  Constants, field layout and carrier types for the timer group quadrature
  decoder control. Assumes a 32-bit Avalon-MM register bus, word aligned.
*/
package tgqd_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_ENC_CTRL   = 32'h4000_3140;
  localparam logic [31:0] ADDR_T0_STATUS  = 32'h4000_3018;
  localparam logic [31:0] ADDR_T1_STATUS  = 32'h4000_3038;
  localparam logic [31:0] ADDR_T2_STATUS  = 32'h4000_3058;
  localparam logic [31:0] ADDR_T3_STATUS  = 32'h4000_3078;
  localparam logic [31:0] ADDR_POS_COUNT  = 32'h4000_3054;
  localparam logic [31:0] ADDR_REV_COUNT  = 32'h4000_3074;
  localparam logic [31:0] ADDR_PHA_COUNT  = 32'h4000_3014;
  localparam logic [31:0] ADDR_PHB_COUNT  = 32'h4000_3034;

  localparam logic [15:0] ENC_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] ENC_CTRL_MASK   = 16'h0FFD;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  // Control field positions
  localparam int MODE_BIT      = 0;
  localparam int SWAP_BIT      = 2;
  localparam int IDX_EDGE_BIT  = 3;
  localparam int PHA_EDGE_LO   = 4;
  localparam int PHB_EDGE_LO   = 6;
  localparam int PHA_DIR_BIT   = 8;
  localparam int PHB_DIR_BIT   = 9;
  localparam int POS_DIR_BIT   = 10;
  localparam int REV_DIR_BIT   = 11;

  // Status flag positions
  localparam int REV_FLAG_BIT  = 4;
  localparam int DIR_FLAG_BIT  = 5;

  // Edge select encodings
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  localparam int NUM_TIMERS = 4;

  typedef struct packed {
    logic       rev_dir_en;
    logic       pos_dir_en;
    logic       phb_dir_en;
    logic       pha_dir_en;
    logic [1:0] phb_edge;
    logic [1:0] pha_edge;
    logic       idx_edge;
    logic       swap;
    logic       mode;
  } tgqd_ctrl_s;

  typedef struct packed {
    logic [3:0] inc;
    logic [3:0] dec;
  } tgqd_count_s;

endpackage : tgqd_pkg

// >>> hdl/tgqd_top.sv
/*
  Timer group quadrature decoder control: encoder control register, input
  synchronisers, phase decoding, four 16-bit encoder counters and the two
  encoder status flags of timers 0..3.
  Counter roles in decoder mode: timer 0 phase A, timer 1 phase B, timer 2
  position, timer 3 revolutions. Counters and flags are readable over the
  bus; the flags clear by writing one at any of the four status addresses.
  Pin edges reach the counters three clocks after they reach the pins.
  Assumes an Avalon-MM master holding each request until waitrequest is
  seen low, encoder pins that may change at any time, and a synchronous
  active-low reset.
*/
`timescale 1ns/10ps
// Overview of operation
// - 16-bit control register, fixed address, zero reset
// - Only timers zero to three join
// - Mode bit selects timer or encoder counting
// - Phase B edge select for position
// - Phase A edge select for position
// - Index edge select for revolution count
// - Direction steers revolution counter when enabled
// - Direction reverses position counter when enabled
// - Direction steers phase B counter when enabled
// - Direction steers phase A counter when enabled
// - Direction change sets flag, write-one clears
// - Index event sets flag, write-one clears
module tgqd_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Avalon-MM slave
  input  wire logic [31:0]       avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Encoder pins
  input  wire logic              encoder_phase_a_in_i,
  input  wire logic              encoder_phase_b_in_i,
  input  wire logic              encoder_index_in_i,
  // Decoder state
  output logic                   decoder_mode_o,
  output logic                   direction_o
);

  tgqd_pkg::tgqd_ctrl_s  ctrl;
  tgqd_pkg::tgqd_count_s cnt_evt;
  logic [15:0]           ctrl_ff;
  logic [2:0]            sync1_ff;
  logic [2:0]            sync2_ff;
  logic [2:0]            prev_ff;
  logic                  dir_ff;
  logic                  dir_chg_flag_ff;
  logic                  rev_flag_ff;
  logic [CNT_W-1:0]      count_ff [tgqd_pkg::NUM_TIMERS];
  logic                  ack_ff;
  logic                  req;
  logic                  wr_acc;
  logic                  encoder_phase_a_in;
  logic                  encoder_phase_b_in;
  logic                  pha_prev;
  logic                  phb_prev;
  logic                  pha_rise;
  logic                  pha_fall;
  logic                  phb_rise;
  logic                  phb_fall;
  logic                  idx_evt;
  logic                  step;
  logic                  nxt_dir;
  logic                  dir_valid;
  logic                  pos_evt;
  logic [31:0]           nxt_rdata;
  logic [15:0]           wmask;
  logic                  ctrl_hit;
  logic                  rd_take;
  logic                  status_hit;
  logic                  status_wr;
  logic [2:0]            pins;
  logic                  pha_any;
  logic                  phb_any;
  logic                  dir_chg_set;
  logic                  dir_chg_clr;
  logic                  rev_set;
  logic                  rev_clr;

  // Field view of the control register
  always_comb begin
    ctrl.mode       = ctrl_ff[tgqd_pkg::MODE_BIT];
    ctrl.swap       = ctrl_ff[tgqd_pkg::SWAP_BIT];
    ctrl.idx_edge   = ctrl_ff[tgqd_pkg::IDX_EDGE_BIT];
    ctrl.pha_edge   = ctrl_ff[tgqd_pkg::PHA_EDGE_LO+1:tgqd_pkg::PHA_EDGE_LO];
    ctrl.phb_edge   = ctrl_ff[tgqd_pkg::PHB_EDGE_LO+1:tgqd_pkg::PHB_EDGE_LO];
    ctrl.pha_dir_en = ctrl_ff[tgqd_pkg::PHA_DIR_BIT];
    ctrl.phb_dir_en = ctrl_ff[tgqd_pkg::PHB_DIR_BIT];
    ctrl.pos_dir_en = ctrl_ff[tgqd_pkg::POS_DIR_BIT];
    ctrl.rev_dir_en = ctrl_ff[tgqd_pkg::REV_DIR_BIT];
  end

  // Edge select decode, shared by both phases
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    if (sel[1]) begin
      edge_hit = rise | fall;
    end else if (sel == tgqd_pkg::EDGE_FALL) begin
      edge_hit = fall;
    end else begin
      edge_hit = rise;
    end
  endfunction : edge_hit

  // Flags mirror at the status address of every encoder timer
  function automatic logic is_status_addr(input logic [31:0] addr);
    is_status_addr = (addr == tgqd_pkg::ADDR_T0_STATUS) || (addr == tgqd_pkg::ADDR_T1_STATUS) ||
                     (addr == tgqd_pkg::ADDR_T2_STATUS) || (addr == tgqd_pkg::ADDR_T3_STATUS);
  endfunction : is_status_addr

  // Up and down request of one counter; a disabled direction control counts up
  function automatic logic [1:0] steer(input logic hit, input logic dir_en, input logic fwd);
    steer = {hit & (~dir_en | fwd), hit & dir_en & ~fwd};
  endfunction : steer

  // ---------------- Bus slave ----------------
  // One wait state: waitrequest drops for one cycle per request
  assign req        = avs_read_i | avs_write_i;
  assign wr_acc     = avs_write_i & ack_ff;
  assign rd_take    = avs_read_i & ~ack_ff;
  assign wmask      = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign ctrl_hit   = avs_address_i == tgqd_pkg::ADDR_ENC_CTRL;
  assign status_hit = is_status_addr(avs_address_i);
  assign status_wr  = wr_acc & avs_byteenable_i[0] & status_hit;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & ~ack_ff);
    end
  end

  always_comb begin
    nxt_rdata = tgqd_pkg::UNMAPPED_DATA;
    if (ctrl_hit) begin
      nxt_rdata[15:0] = ctrl_ff;
    end else if (status_hit) begin
      nxt_rdata[tgqd_pkg::DIR_FLAG_BIT] = dir_chg_flag_ff;
      nxt_rdata[tgqd_pkg::REV_FLAG_BIT] = rev_flag_ff;
    end else if (avs_address_i == tgqd_pkg::ADDR_PHA_COUNT) begin
      nxt_rdata[CNT_W-1:0] = count_ff[0];
    end else if (avs_address_i == tgqd_pkg::ADDR_PHB_COUNT) begin
      nxt_rdata[CNT_W-1:0] = count_ff[1];
    end else if (avs_address_i == tgqd_pkg::ADDR_POS_COUNT) begin
      nxt_rdata[CNT_W-1:0] = count_ff[2];
    end else if (avs_address_i == tgqd_pkg::ADDR_REV_COUNT) begin
      nxt_rdata[CNT_W-1:0] = count_ff[3];
    end
  end

  // Loaded as the read is taken, held until the next read
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= tgqd_pkg::UNMAPPED_DATA;
    end else if (rd_take) begin
      avs_readdata_o <= nxt_rdata;
    end
  end

  // ---------------- Control register ----------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= tgqd_pkg::ENC_CTRL_RESET;
    end else if (wr_acc && ctrl_hit) begin
      ctrl_ff <= (ctrl_ff & ~(wmask & tgqd_pkg::ENC_CTRL_MASK)) |
                 (avs_writedata_i[15:0] & wmask & tgqd_pkg::ENC_CTRL_MASK);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      decoder_mode_o <= 1'b0;
    end else begin
      decoder_mode_o <= ctrl.mode;
    end
  end

  // ---------------- Input synchronisers ----------------
  // Two flops against metastability; prev_ff is the edge reference
  assign pins = {encoder_index_in_i, encoder_phase_b_in_i, encoder_phase_a_in_i};

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff  <= 3'h0;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // ---------------- Decoding ----------------
  assign encoder_phase_a_in      = ctrl.swap ? sync2_ff[1] : sync2_ff[0];
  assign encoder_phase_b_in      = ctrl.swap ? sync2_ff[0] : sync2_ff[1];
  assign pha_prev = ctrl.swap ? prev_ff[1]  : prev_ff[0];
  assign phb_prev = ctrl.swap ? prev_ff[0]  : prev_ff[1];
  assign pha_rise = encoder_phase_a_in & ~pha_prev;
  assign pha_fall = ~encoder_phase_a_in & pha_prev;
  assign phb_rise = encoder_phase_b_in & ~phb_prev;
  assign phb_fall = ~encoder_phase_b_in & phb_prev;
  assign pha_any  = pha_rise | pha_fall;
  assign phb_any  = phb_rise | phb_fall;

  // A edge with A != B after it means A leads (forward); B edge with A == B likewise
  // Edges on both phases at once carry no direction: the old one is kept
  always_comb begin
    nxt_dir   = dir_ff;
    dir_valid = 1'b0;
    if (pha_any && !phb_any) begin
      nxt_dir   = encoder_phase_a_in ^ encoder_phase_b_in;
      dir_valid = 1'b1;
    end else if (phb_any && !pha_any) begin
      nxt_dir   = ~(encoder_phase_a_in ^ encoder_phase_b_in);
      dir_valid = 1'b1;
    end
  end

  assign step    = ctrl.mode & dir_valid;
  assign pos_evt = ctrl.mode & (edge_hit(ctrl.pha_edge, pha_rise, pha_fall) |
                                edge_hit(ctrl.phb_edge, phb_rise, phb_fall));
  assign idx_evt = ctrl.mode & (ctrl.idx_edge ? (~sync2_ff[2] & prev_ff[2])
                                              : (sync2_ff[2] & ~prev_ff[2]));

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dir_ff <= 1'b1;
    end else if (step) begin
      dir_ff <= nxt_dir;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      direction_o <= 1'b1;
    end else if (step) begin
      direction_o <= nxt_dir;
    end
  end

  // Count events: a disabled direction control always counts up
  always_comb begin
    cnt_evt.inc = 4'h0;
    cnt_evt.dec = 4'h0;
    if (ctrl.mode) begin
      {cnt_evt.inc[0], cnt_evt.dec[0]} = steer(pha_any, ctrl.pha_dir_en, nxt_dir);
      {cnt_evt.inc[1], cnt_evt.dec[1]} = steer(phb_any, ctrl.phb_dir_en, nxt_dir);
      {cnt_evt.inc[2], cnt_evt.dec[2]} = steer(pos_evt, ctrl.pos_dir_en, nxt_dir);
      // Revolutions take the direction held before the index edge
      {cnt_evt.inc[3], cnt_evt.dec[3]} = steer(idx_evt, ctrl.rev_dir_en, dir_ff);
    end
  end

  // Timers 0..3 only; one counter per role
  for (genvar t = 0; t < tgqd_pkg::NUM_TIMERS; t++) begin : g_cnt
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        count_ff[t] <= '0;
      end else if (cnt_evt.inc[t]) begin
        count_ff[t] <= count_ff[t] + CNT_W'(1);
      end else if (cnt_evt.dec[t]) begin
        count_ff[t] <= count_ff[t] - CNT_W'(1);
      end
    end
  end

  // ---------------- Status flags, set wins over clear ----------------
  assign dir_chg_set = step & (nxt_dir != dir_ff);
  assign dir_chg_clr = status_wr & avs_writedata_i[tgqd_pkg::DIR_FLAG_BIT];
  assign rev_set     = idx_evt;
  assign rev_clr     = status_wr & avs_writedata_i[tgqd_pkg::REV_FLAG_BIT];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dir_chg_flag_ff <= 1'b0;
    end else if (dir_chg_set) begin
      dir_chg_flag_ff <= 1'b1;
    end else if (dir_chg_clr) begin
      dir_chg_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rev_flag_ff <= 1'b0;
    end else if (rev_set) begin
      rev_flag_ff <= 1'b1;
    end else if (rev_clr) begin
      rev_flag_ff <= 1'b0;
    end
  end

endmodule : tgqd_top

// >>> verif/tgqd_asserts.sv
/* Checker on the ports of tgqd_top.
   Assumes it is bound into every tgqd_top instance. */
`timescale 1ns/10ps
module tgqd_asserts #(
  parameter int CNT_W = 16
) (
  // Watched ports
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [31:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        encoder_phase_a_in_i,
  input wire logic        encoder_phase_b_in_i,
  input wire logic        decoder_mode_o,
  input wire logic        direction_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       mode_exp_ff;
  logic [1:0] pin_prev_ff;
  logic [3:0] pin_hist_ff;
  wire        rd_ack  = avs_read_i && !avs_waitrequest_o;
  wire        wr_ctrl = avs_write_i && !avs_waitrequest_o && avs_address_i == tgqd_pkg::ADDR_ENC_CTRL;
  // Recent pin activity, for tying direction changes to a cause
  always_ff @(posedge ref_clk_i) begin
    pin_prev_ff <= {encoder_phase_a_in_i, encoder_phase_b_in_i};
    pin_hist_ff <= {pin_hist_ff[2:0], pin_prev_ff != {encoder_phase_a_in_i, encoder_phase_b_in_i}};
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) mode_exp_ff <= 1'b0;
    else if (wr_ctrl) mode_exp_ff <= avs_writedata_i[tgqd_pkg::MODE_BIT];
  end
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_ANSWER: assert property (s_req |=> s_ack)
    else $error("request not answered after one wait cycle");
  AST_NO_SPURIOUS: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  AST_RESET_VALS: assert property ($rose(rst_n_i) |-> avs_waitrequest_o && !decoder_mode_o && direction_o)
    else $error("bad state after reset");
  AST_MODE_FOLLOWS: assert property (wr_ctrl |=> ##[0:1] decoder_mode_o == mode_exp_ff)
    else $error("mode output not following control write");
  AST_MODE_CAUSE: assert property ($changed(decoder_mode_o) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("mode changed without control write");
  AST_UNMAPPED_RD: assert property (rd_ack && avs_address_i[31:16] != 16'h4000 |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_CTRL_RSVD: assert property (rd_ack && avs_address_i == tgqd_pkg::ADDR_ENC_CTRL
    |-> (avs_readdata_o & ~{16'h0000, tgqd_pkg::ENC_CTRL_MASK}) == 32'h0000_0000)
    else $error("reserved control bits not zero");
  AST_RDATA_HOLD: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data changed without read");
  AST_DIR_CAUSE: assert property ($changed(direction_o) |-> pin_hist_ff != 4'h0)
    else $error("direction changed without pin edge");
endmodule : tgqd_asserts
bind tgqd_top tgqd_asserts #(.CNT_W(CNT_W)) tgqd_asserts_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .encoder_phase_a_in_i(encoder_phase_a_in_i), .encoder_phase_b_in_i(encoder_phase_b_in_i),
  .decoder_mode_o(decoder_mode_o), .direction_o(direction_o));

// >>> verif/tgqd_enc_model.sv
/* Incremental encoder model: two phases and index.
   Assumes one-cycle step requests from the bench. */
`timescale 1ns/10ps
module tgqd_enc_model (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Requests
  input  wire logic step_i,
  input  wire logic fwd_i,
  input  wire logic index_i,
  // Encoder lines
  output logic      phase_a_o,
  output logic      phase_b_o,
  output logic      index_o
);
  logic [1:0] pos_ff;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) pos_ff <= 2'h0;
    else if (step_i) pos_ff <= fwd_i ? pos_ff + 2'h1 : pos_ff - 2'h1;
  end
  always_ff @(posedge ref_clk_i) index_o <= rst_n_i && index_i;
  // Forward runs A ahead of B
  assign phase_a_o = pos_ff[0] ^ pos_ff[1];
  assign phase_b_o = pos_ff[1];
endmodule : tgqd_enc_model

// >>> verif/test_timer_group_quadrature_decoder_control.sv
/* Self-checking bench for tgqd_top with an encoder model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/10ps
module test_timer_group_quadrature_decoder_control;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [31:0] addr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        step = 1'b0;
  logic        fwd = 1'b1;
  logic        idx = 1'b0;
  wire  [31:0] rdata;
  wire         wait_req, mode_o, dir_o, pa, pb, pz;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;
  logic [15:0] ctrl, exp_pos, exp_a, exp_b;
  logic [31:0] q, d, p0, r0, a0, b0;
  logic [1:0]  o, bpos = 2'h0;
  logic [17:0] r;
  logic        exp_dir = 1'b1;
  logic        dchg, sw_last = 1'b0;
  tgqd_top tgqd_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .encoder_phase_a_in_i(pa), .encoder_phase_b_in_i(pb),
    .encoder_index_in_i(pz), .decoder_mode_o(mode_o), .direction_o(dir_o));
  tgqd_enc_model tgqd_enc_model_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .step_i(step), .fwd_i(fwd),
    .index_i(idx), .phase_a_o(pa), .phase_b_o(pb), .index_o(pz));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dv, output logic [31:0] rv);
    @(posedge ref_clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= dv;
    do @(posedge ref_clk_i); while (wait_req !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Returns phase A moved, direction and position increment of one step
  function automatic logic [17:0] pos_step(input logic [15:0] c, input logic [1:0] ov, input logic [1:0] nv);
    logic [1:0] x, y, s;
    logic       am, e, f;
    x = c[2] ? {ov[0], ov[1]} : ov;
    y = c[2] ? {nv[0], nv[1]} : nv;
    am = x[1] != y[1];
    s = am ? c[5:4] : c[7:6];
    e = am ? y[1] : y[0];
    f = am ? (y[1] != y[0]) : (y[1] == y[0]);
    if (!(s[1] || (s[0] ^ e))) return {am, f, 16'h0000};
    return {am, f, (c[10] && !f) ? 16'hFFFF : 16'h0001};
  endfunction : pos_step
  initial begin
    void'($urandom(78));
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, tgqd_pkg::ADDR_ENC_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    repeat (4) begin
      d = $urandom;
      bus(1'b1, tgqd_pkg::ADDR_ENC_CTRL, d, q);
      bus(1'b1, 32'h4000_3144, 32'hFFFF_FFFF, q);
      bus(1'b0, tgqd_pkg::ADDR_ENC_CTRL, 32'h0000_0000, q);
      chk(q, {16'h0000, d[15:0] & tgqd_pkg::ENC_CTRL_MASK});
    end
    bus(1'b0, 32'h5000_0000, 32'h0000_0000, q);
    chk(q, tgqd_pkg::UNMAPPED_DATA);
    $display("test registers done");
    for (int t = 0; t < 6; t++) begin
      ctrl = 16'($urandom) & 16'h0F0C;
      ctrl[5:4] = (t == 5) ? 2'h3 : 2'(t % 3);
      ctrl[7:6] = 2'((t + 1) % 3);
      ctrl[0] = (t != 0);
      if (t == 0) ctrl[2] = 1'b0;
      if (bpos[0]) ctrl[2] = sw_last;
      sw_last = ctrl[2];
      fwd <= (t == 0) ? 1'b1 : 1'($urandom);
      bus(1'b1, tgqd_pkg::ADDR_ENC_CTRL, {16'h0000, ctrl}, q);
      bus(1'b1, tgqd_pkg::ADDR_T0_STATUS, 32'h0000_0030, q);
      bus(1'b0, tgqd_pkg::ADDR_POS_COUNT, 32'h0000_0000, p0);
      bus(1'b0, tgqd_pkg::ADDR_REV_COUNT, 32'h0000_0000, r0);
      bus(1'b0, tgqd_pkg::ADDR_PHA_COUNT, 32'h0000_0000, a0);
      bus(1'b0, tgqd_pkg::ADDR_PHB_COUNT, 32'h0000_0000, b0);
      exp_pos = p0[15:0];
      exp_a = a0[15:0];
      exp_b = b0[15:0];
      dchg = 1'b0;
      n = 1 + $urandom % 8;
      repeat (n) begin
        step <= 1'b1;
        @(posedge ref_clk_i);
        step <= 1'b0;
        o = {bpos[0] ^ bpos[1], bpos[1]};
        bpos = fwd ? bpos + 2'h1 : bpos - 2'h1;
        r = pos_step(ctrl, o, {bpos[0] ^ bpos[1], bpos[1]});
        if (ctrl[0]) begin
          exp_pos += r[15:0];
          if (r[17]) exp_a += (ctrl[8] && !r[16]) ? 16'hFFFF : 16'h0001;
          else exp_b += (ctrl[9] && !r[16]) ? 16'hFFFF : 16'h0001;
          dchg |= r[16] != exp_dir;
          exp_dir = r[16];
        end
        repeat (6) @(posedge ref_clk_i);
      end
      bus(1'b0, tgqd_pkg::ADDR_POS_COUNT, 32'h0000_0000, q);
      chk(q, {16'h0000, exp_pos});
      bus(1'b0, tgqd_pkg::ADDR_T0_STATUS, 32'h0000_0000, q);
      chk(q, {26'h0, dchg, 5'h0});
      chk({31'h0, dir_o}, {31'h0, exp_dir});
      chk({31'h0, mode_o}, {31'h0, ctrl[0]});
      bus(1'b0, tgqd_pkg::ADDR_PHA_COUNT, 32'h0000_0000, q);
      chk(q, {16'h0000, exp_a});
      bus(1'b0, tgqd_pkg::ADDR_PHB_COUNT, 32'h0000_0000, q);
      chk(q, {16'h0000, exp_b});
      bus(1'b1, tgqd_pkg::ADDR_T3_STATUS, 32'h0000_0030, q);
      idx <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      bus(1'b0, tgqd_pkg::ADDR_T3_STATUS, 32'h0000_0000, q);
      chk(q, {27'h0, ctrl[0] && !ctrl[3], 4'h0});
      bus(1'b1, tgqd_pkg::ADDR_T3_STATUS, 32'h0000_0030, q);
      idx <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      bus(1'b0, tgqd_pkg::ADDR_T3_STATUS, 32'h0000_0000, q);
      chk(q, {27'h0, ctrl[0] && ctrl[3], 4'h0});
      bus(1'b0, tgqd_pkg::ADDR_REV_COUNT, 32'h0000_0000, q);
      chk(q, {16'h0000, r0[15:0] + (ctrl[0] ? ((ctrl[11] && !exp_dir) ? 16'hFFFF : 16'h0001) : 16'h0000)});
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule : test_timer_group_quadrature_decoder_control
